// ==== shared/tsnf_pkg.sv ====
// package: register map, field positions and constants for the timer status and input filter block
package tsnf_pkg;
   // ======================================
   // register map
   localparam logic [11:0] ADDR_STAT0 = 12'hf23;
   localparam logic [11:0] ADDR_STAT1 = 12'hf27;
   localparam logic [11:0] ADDR_STAT2 = 12'hf2b;
   localparam logic [11:0] ADDR_NFC0 = 12'hf2c;
   localparam logic [11:0] ADDR_NFC1 = 12'hf2d;
   localparam logic [11:0] ADDR_NFC2 = 12'hf2e;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'hf30;
   // ======================================
   // status fields
   localparam int STAT_NOISE_BIT = 7;
   localparam int STAT_OVR1_BIT = 5;
   localparam int STAT_OVR0_BIT = 4;
   localparam int STAT_RELOAD_BIT = 3;
   localparam int STAT_EVT1_BIT = 1;
   localparam int STAT_EVT0_BIT = 0;
   localparam logic [7:0] STAT_USED_MASK = 8'hbb;
   localparam logic [7:0] STAT_RESET = 8'h00;
   // ======================================
   // filter control fields
   localparam int NFC_EN_BIT = 7;
   localparam int NFC_SEL_LSB = 4;
   localparam int NFC_SEL_W = 3;
   localparam logic [7:0] NFC_USED_MASK = 8'hf0;
   localparam logic [7:0] NFC_RESET = 8'h00;
   localparam int FILT_MIN_W = 2;
   localparam int FILT_MAX_W = 9;
   // ======================================
   // timing: filter sample rate divider
   localparam int SAMPLE_DIV = 8;
   localparam int NUM_TIMERS = 3;
endpackage : tsnf_pkg

// ==== core/tsnf_filter.sv ====
// module: one timer input noise filter with up/down counter
`timescale 1ns/10ps
`default_nettype none
module tsnf_filter
   import tsnf_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic sample_en,
   input wire logic pin_sync,
   input wire logic enable,
   input wire logic [2:0] width_sel,
   output logic filt_out,
   output logic noise_pulse
);
   typedef struct packed {
      logic [FILT_MAX_W-1:0] cnt;
      logic out;
      logic noise;
   } tsnf_filt_type;
   tsnf_filt_type st_reg, st_next;
   logic [FILT_MAX_W-1:0] top;

   always_comb begin
      // full scale is 2^(width)-1, width = 2 + code
      top = FILT_MAX_W'((10'h001 << (FILT_MIN_W + int'(width_sel))) - 10'h001);
      st_next = st_reg;
      st_next.noise = 1'b0;
      if (!enable) begin
         st_next.out = pin_sync;
         st_next.cnt = pin_sync ? top : '0;
      end else if (sample_en) begin
         if (pin_sync && st_reg.cnt < top) begin
            st_next.cnt = st_reg.cnt + 1'b1;
         end else if (!pin_sync && st_reg.cnt != '0) begin
            st_next.cnt = st_reg.cnt - 1'b1;
         end else if (st_reg.cnt > top) begin
            st_next.cnt = top;
         end
         if (st_next.cnt >= top) begin
            st_next.out = 1'b1;
         end else if (st_next.cnt == '0) begin
            st_next.out = 1'b0;
         end
         // a sample that disagrees with the settled value
         if (pin_sync != st_reg.out) begin
            st_next.noise = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign filt_out = st_reg.out;
   assign noise_pulse = st_reg.noise;
endmodule : tsnf_filter
`default_nettype wire

// ==== core/tsnf_top.sv ====
// module: status flags, filter control registers and input filters for three timers
// How it works
// - filter on: sample disagreeing with filtered value sets noise flag
// - capture/compare event on a channel sets its event flag always
// - event flag clears only on write of one; zero leaves it
// - event while event flag still set sets that channel's overrun flag
// - clearing an event flag also clears that channel's overrun flag
// - counter reload to restart count sets reload flag
// - status bits: 7 noise, 5/4 overrun, 3 reload, 1/0 event
// - filter enable bit 7 routes input through filter, else bypass
// - bits 6:4 select the filter counter width
// - codes 000 to 111 select 2 to 9 bit counters
// - all status flags and filter control bits reset to zero
`timescale 1ns/10ps
`default_nettype none
module tsnf_top
   import tsnf_pkg::*;
#(
   parameter int SAMPLE_DIVIDE = SAMPLE_DIV
)(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   input wire logic [2:0] timer_input_pin,
   input wire logic [2:0] chan0_event,
   input wire logic [2:0] chan1_event,
   input wire logic [2:0] reload_event,
   output logic [2:0] filtered_input,
   output logic irq
);
   import tsnf_pkg::*;

   // ======================================
   // state
   typedef struct packed {
      logic [NUM_TIMERS-1:0][7:0] stat;
      logic [NUM_TIMERS-1:0][7:0] nfc;
      logic [NUM_TIMERS-1:0][7:0] mask;
      logic [7:0] rdata;
      logic [NUM_TIMERS-1:0] filt;
      logic irq;
      logic [3:0] div;
      logic samp;
      logic [NUM_TIMERS-1:0] s1;
      logic [NUM_TIMERS-1:0] s2;
   } tsnf_state_type;
   tsnf_state_type st_reg, st_next;

   logic [NUM_TIMERS-1:0] filt_w;
   logic [NUM_TIMERS-1:0] noise_w;
   logic [7:0] clr;
   logic any;

   // ======================================
   // filters
   genvar g;
   generate
      for (g = 0; g < NUM_TIMERS; g++) begin : gen_filt
         tsnf_filter u_filt (
            .clock(clock),
            .nrst(nrst),
            .sample_en(st_reg.samp),
            .pin_sync(st_reg.s2[g]),
            .enable(st_reg.nfc[g][NFC_EN_BIT]),
            .width_sel(st_reg.nfc[g][NFC_SEL_LSB +: NFC_SEL_W]),
            .filt_out(filt_w[g]),
            .noise_pulse(noise_w[g])
         );
      end
   endgenerate

   // ======================================
   // next state
   always_comb begin
      st_next = st_reg;
      clr = '0;
      any = 1'b0;
      st_next.s1 = timer_input_pin;
      st_next.s2 = st_reg.s1;
      st_next.filt = filt_w;
      if (int'(st_reg.div) >= SAMPLE_DIVIDE - 1) begin
         st_next.div = '0;
         st_next.samp = 1'b1;
      end else begin
         st_next.div = st_reg.div + 1'b1;
         st_next.samp = 1'b0;
      end
      for (int t = 0; t < NUM_TIMERS; t++) begin
         clr = 8'h00;
         if (wr_en && addr == (t == 0 ? ADDR_STAT0 : t == 1 ? ADDR_STAT1 : ADDR_STAT2)) begin
            clr = wdata & STAT_USED_MASK;
            // clearing an event flag takes its overrun flag too
            clr[STAT_OVR0_BIT] = wdata[STAT_EVT0_BIT];
            clr[STAT_OVR1_BIT] = wdata[STAT_EVT1_BIT];
         end
         st_next.stat[t] = st_reg.stat[t] & ~clr & STAT_USED_MASK;
         // sets win over clears
         if (chan0_event[t]) begin
            st_next.stat[t][STAT_EVT0_BIT] = 1'b1;
            if (st_reg.stat[t][STAT_EVT0_BIT]) begin
               st_next.stat[t][STAT_OVR0_BIT] = 1'b1;
            end
         end
         if (chan1_event[t]) begin
            st_next.stat[t][STAT_EVT1_BIT] = 1'b1;
            if (st_reg.stat[t][STAT_EVT1_BIT]) begin
               st_next.stat[t][STAT_OVR1_BIT] = 1'b1;
            end
         end
         if (reload_event[t]) begin
            st_next.stat[t][STAT_RELOAD_BIT] = 1'b1;
         end
         if (noise_w[t] && st_reg.nfc[t][NFC_EN_BIT]) begin
            st_next.stat[t][STAT_NOISE_BIT] = 1'b1;
         end
         if (wr_en && addr == (t == 0 ? ADDR_NFC0 : t == 1 ? ADDR_NFC1 : ADDR_NFC2)) begin
            st_next.nfc[t] = wdata & NFC_USED_MASK;
         end
         if (wr_en && addr == ADDR_IRQ_MASK + 12'(t)) begin
            st_next.mask[t] = wdata & STAT_USED_MASK;
         end
         if ((st_next.stat[t] & st_next.mask[t]) != 8'h00) begin
            any = 1'b1;
         end
      end
      st_next.irq = any;
      st_next.rdata = 8'h00;
      if (rd_en) begin
         case (addr)
            ADDR_STAT0: st_next.rdata = st_reg.stat[0];
            ADDR_STAT1: st_next.rdata = st_reg.stat[1];
            ADDR_STAT2: st_next.rdata = st_reg.stat[2];
            ADDR_NFC0: st_next.rdata = st_reg.nfc[0];
            ADDR_NFC1: st_next.rdata = st_reg.nfc[1];
            ADDR_NFC2: st_next.rdata = st_reg.nfc[2];
            ADDR_IRQ_MASK: st_next.rdata = st_reg.mask[0];
            ADDR_IRQ_MASK + 12'h001: st_next.rdata = st_reg.mask[1];
            ADDR_IRQ_MASK + 12'h002: st_next.rdata = st_reg.mask[2];
            default: st_next.rdata = 8'h00;
         endcase
      end
   end

   // ======================================
   // registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata = st_reg.rdata;
   assign filtered_input = st_reg.filt;
   assign irq = st_reg.irq;
endmodule : tsnf_top
`default_nettype wire

// ==== dv/tsnf_asserts.sv ====
// checker: port assertions for the timer status block
`timescale 1ns/10ps
`default_nettype none
module tsnf_asserts
   import tsnf_pkg::*;
#(parameter int SAMPLE_DIVIDE = SAMPLE_DIV)(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] rdata,
   input wire logic [2:0] chan0_event,
   input wire logic [2:0] reload_event,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   logic rs, cw;
   assign rs = rd_en && addr == ADDR_STAT0;
   assign cw = wr_en && addr == ADDR_STAT0;
   // ==========
   // assertions
   chk_stat_rsvd: assert property (rs |=> !rdata[6] && !rdata[2]) else $error("reserved set");
   chk_nfc_rsvd: assert property (rd_en && addr == ADDR_NFC0 |=> rdata[3:0] == 4'h0) else $error("nfc low");
   chk_event_set: assert property (chan0_event[0] ##1 !(cw && wdata[0]) ##1 rs |=> rdata[0]) else $error("evt");
   chk_overrun_set: assert property (chan0_event[0] ##1 chan0_event[0] ##1 !(cw && wdata[0]) ##1 rs |=> rdata[4])
      else $error("ovr");
   chk_reload_set: assert property (reload_event[0] ##1 !(cw && wdata[3]) [*2] ##1 rs |=> rdata[3])
      else $error("reload");
   chk_clear_both: assert property (cw && wdata[0] && !chan0_event[0] ##1 rs |=> !rdata[0] && !rdata[4])
      else $error("clear");
   chk_zero_keeps: assert property (chan0_event[0] ##1 cw && !wdata[0] ##1 rs |=> rdata[0]) else $error("kept");
   chk_reset_clear: assert property (disable iff (1'b0) !nrst |=> rdata == 8'h00 && !irq) else $error("rst");
endmodule : tsnf_asserts
bind tsnf_top tsnf_asserts #(.SAMPLE_DIVIDE(SAMPLE_DIVIDE)) u_chk (.clock, .nrst, .addr, .wdata, .wr_en, .rd_en,
   .rdata, .chan0_event, .reload_event, .irq);
`default_nettype wire

// ==== dv/tsnf_pin_model.sv ====
// model: external signal on the three timer input pins
`timescale 1ns/10ps
`default_nettype none
module tsnf_pin_model (
   input wire logic clock,
   input wire logic [2:0] level,
   input wire logic [2:0] noisy,
   output logic [2:0] pin
);
   logic tg = 1'b0;
   // ==========
   // glitch pattern, off the sampling edge
   always @(negedge clock) tg <= ~tg;
   assign pin = level ^ (noisy & {3{tg}});
endmodule : tsnf_pin_model
`default_nettype wire

// ==== dv/test_timer_status_noise_filter.sv ====
// testbench: timer status flags, interrupt and input filter
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("FAIL %s %h %h", n, e, g); end end
module test_timer_status_noise_filter;
   import tsnf_pkg::*;
   localparam int SD = 2;
   logic clock = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0, v1 = 1'b0, irq;
   logic [2:0] c0 = 3'h0, c1 = 3'h0, rl = 3'h0, lv = 3'h0, nz = 3'h0, pin, filt;
   logic [7:0] wdata = 8'h00, rexp = 8'h00, e1 = 8'h00, rdata, m, w;
   logic [11:0] addr = 12'h000, s;
   int fails = 0, check_count = 0, n;
   integer seed = 32'hb334;
   tsnf_top #(.SAMPLE_DIVIDE(SD)) u_tsnf_top (.clock, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata,
      .timer_input_pin(pin), .chan0_event(c0), .chan1_event(c1), .reload_event(rl), .filtered_input(filt), .irq);
   tsnf_pin_model u_tsnf_pin_model (.clock, .level(lv), .noisy(nz), .pin);
   initial forever #4 clock = ~clock;
   always @(posedge clock) begin
      v1 <= rd_en;
      e1 <= rexp;
   end
   always @(negedge clock) if (v1) `CHK("rdata", e1, rdata)
   // ==========
   // helpers
   function automatic logic [7:0] clr(input logic [7:0] st, input logic [7:0] wv);
      clr = st & ~wv;
      if (wv[0]) clr[4] = 1'b0;
      if (wv[1]) clr[5] = 1'b0;
   endfunction : clr
   task automatic bus(input logic wv, input logic rv, input logic [11:0] a, input logic [7:0] d);
      wr_en <= wv;
      rd_en <= rv;
      addr <= a;
      wdata <= d;
      rexp <= d;
      @(posedge clock);
   endtask : bus
   task automatic waitf(input logic e, input int lim);
      int k = 0;
      while (filt[0] !== e && k < lim) begin
         @(posedge clock);
         k++;
      end
      `CHK("filt", e, filt[0])
   endtask : waitf
   task automatic summarize();
      if (fails == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   initial begin
      #200000;
      fails++;
      summarize();
   end
   // ==========
   // scenarios
   initial begin
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         bus(0, 1, ADDR_STAT0 + 12'(4 * i), 8'h00);
         bus(0, 1, ADDR_NFC0 + 12'(i), 8'h00);
      end
      bus(1, 0, 12'hf24, 8'hff);
      bus(0, 1, 12'hf24, 8'h00);
      nz <= 3'h6;
      for (int t = 0; t < 3; t++) begin
         s = ADDR_STAT0 + 12'(4 * t);
         c0 <= 3'h1 << t;
         c1 <= 3'h1 << t;
         rl <= 3'h1 << t;
         bus(0, 0, s, 8'h00);
         c1 <= 3'h0;
         rl <= 3'h0;
         bus(0, 0, s, 8'h00);
         c0 <= 3'h0;
         bus(1, 0, s, 8'h00);
         bus(0, 1, s, 8'h1b);
         m = 8'($random(seed));
         bus(1, 0, ADDR_IRQ_MASK + 12'(t), m);
         bus(0, 1, ADDR_IRQ_MASK + 12'(t), m & STAT_USED_MASK);
         bus(0, 0, s, 8'h00);
         `CHK("irq", |(8'h1b & m), irq)
         w = 8'($random(seed)) & STAT_USED_MASK;
         bus(1, 0, s, w);
         bus(0, 1, s, clr(8'h1b, w));
         bus(1, 0, s, 8'hbb);
         bus(0, 1, s, 8'h00);
         bus(0, 0, s, 8'h00);
         bus(0, 0, s, 8'h00);
         `CHK("irq", 1'b0, irq)
      end
      for (int c = 0; c < 8; c++) begin
         n = ((1 << (c + 2)) - 1) * SD;
         bus(1, 0, ADDR_NFC0, {1'b1, 3'(c), 4'h0});
         bus(0, 1, ADDR_NFC0, {1'b1, 3'(c), 4'h0});
         bus(0, 0, ADDR_NFC0, 8'h00);
         lv <= 3'h1;
         repeat (n - 2) @(posedge clock);
         `CHK("hold", 1'b0, filt[0])
         waitf(1'b1, n + 12);
         lv <= 3'h0;
         repeat (n - 2) @(posedge clock);
         `CHK("hold", 1'b1, filt[0])
         waitf(1'b0, n + 12);
      end
      bus(0, 1, ADDR_STAT0, 8'h80);
      bus(1, 0, ADDR_NFC0, 8'h00);
      bus(1, 0, ADDR_STAT0, 8'h80);
      bus(0, 0, ADDR_STAT0, 8'h00);
      nz <= 3'h7;
      lv <= 3'h1;
      repeat (40) @(posedge clock);
      nz <= 3'h0;
      repeat (8) @(posedge clock);
      `CHK("bypass", 3'h1, filt)
      bus(0, 1, ADDR_STAT0, 8'h00);
      bus(1, 0, ADDR_NFC1, 8'hff);
      bus(0, 1, ADDR_NFC1, 8'hf0);
      bus(0, 0, ADDR_NFC1, 8'h00);
      summarize();
   end
endmodule : test_timer_status_noise_filter
`default_nettype wire
